// ---- verilog/otfs_pkg.sv ----
// Package for the output terminal function select block
package otfs_pkg;

  // ----------------------------------------------------------------
  // Parameter addresses (group in high byte, index in low byte)
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_RELAY_FUNC = 16'h020D;
  localparam logic [15:0] ADDR_OC1_FUNC = 16'h0210;
  localparam logic [15:0] ADDR_OC2_FUNC = 16'h0211;
  localparam logic [15:0] ADDR_POLARITY = 16'h0212;
  localparam logic [15:0] ADDR_OUT_STATUS = 16'h0233;
  localparam logic [15:0] ADDR_ANALOG_SEL = 16'h032C;
  localparam logic [15:0] ADDR_LEVEL_HIGH = 16'h032D;
  localparam logic [15:0] ADDR_LEVEL_LOW = 16'h032E;
  localparam logic [15:0] ADDR_CARD_CTRL = 16'h2640;
  localparam logic [15:0] ADDR_FIELDBUS_CTRL = 16'h2641;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] FIELDBUS_CTRL_RESET = 16'h0001;
  localparam logic [15:0] CARD_CTRL_RESET = 16'h0000;
  localparam logic [15:0] POLARITY_RESET = 16'h0000;
  localparam logic [7:0] FUNC_RESET = 8'h00;
  // Thresholds in 0.1 percent of span: 50.0 and 10.0 percent
  localparam logic [15:0] LEVEL_HIGH_RESET = 16'h01F4;
  localparam logic [15:0] LEVEL_LOW_RESET = 16'h0064;
  localparam logic ANALOG_SEL_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Terminal bit positions and writable polarity bits
  // ----------------------------------------------------------------
  localparam int unsigned TERM_COUNT = 3;
  localparam int unsigned TERM_BITS [TERM_COUNT] = '{0, 3, 4};
  localparam logic [15:0] POLARITY_WRITE_MASK = 16'hFFF9;

  // ----------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    OTFS_FN_NONE = 8'h00,
    OTFS_FN_FIELDBUS = 8'h32,
    OTFS_FN_CARD = 8'h34,
    OTFS_FN_SAFE_A = 8'h42,
    OTFS_FN_LEVEL = 8'h43,
    OTFS_FN_SAFE_B = 8'h44,
    OTFS_FN_TORQUE3 = 8'h49,
    OTFS_FN_TORQUE4 = 8'h4A
  } otfs_func_t;

  // Condition inputs from other drive logic
  typedef struct packed {
    logic safeTorqueOff;
    logic safetyLossFault;
    logic overTorque3;
    logic overTorque4;
  } otfs_cond_t;

  // Parameter access request
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [15:0] addr;
    logic [15:0] wrData;
  } otfs_param_req_t;

endpackage

// ---- verilog/otfs_term_select.sv ----
// Per-terminal function selection
`timescale 1ns/1ps
module otfs_term_select (
  input wire logic [7:0] funcCode,
  input wire logic fieldbusBit,
  input wire logic cardBit,
  input wire otfs_pkg::otfs_cond_t cond,
  input wire logic levelReached,
  output logic active
);
  import otfs_pkg::*;

  always_comb begin
    case (funcCode)
      OTFS_FN_FIELDBUS: active = fieldbusBit;
      OTFS_FN_CARD: active = cardBit;
      OTFS_FN_SAFE_A: active = cond.safeTorqueOff | cond.safetyLossFault;
      OTFS_FN_SAFE_B: active = ~(cond.safeTorqueOff | cond.safetyLossFault);
      OTFS_FN_LEVEL: active = levelReached;
      OTFS_FN_TORQUE3: active = cond.overTorque3;
      OTFS_FN_TORQUE4: active = cond.overTorque4;
      default: active = 1'b0;
    endcase
  end

endmodule // otfs_term_select

// ---- verilog/otfs_output_terminal.sv ----
// Output terminal function select top level
//
// Functional notes
// - Code 50 drives relay, open collectors from object bits 0, 3, 4; resets 0x01.
// - Card function copies card word bits 0, 3, 4 to the three terminals.
// - Safety logic A open normally, closed on torque off or loss; B inverse.
// - Code 67 turns on above high level, off below low, else holds.
// - A setting picks voltage or current analog input for the comparator.
// - Comparator high threshold defaults to 50 percent of span.
// - Comparator low threshold defaults to 10 percent of span.
// - Code 73 asserts output when the third over-torque detector trips.
// - Code 74 asserts output when the fourth over-torque detector trips.
// - A polarity bit of 1 inverts that terminal's output.
// - 16-bit polarity field: bit 0 relay, bit 3 and 4 open collectors.
`timescale 1ns/1ps
module otfs_output_terminal (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEnable,
  input wire otfs_pkg::otfs_param_req_t paramReq,
  input wire otfs_pkg::otfs_cond_t cond,
  input wire logic [15:0] voltageAnalogIn,
  input wire logic [15:0] currentAnalogIn,
  output logic [15:0] paramRdData,
  output logic paramRdValid,
  output logic relayOutput,
  output logic openCollectorOutFirst,
  output logic openCollectorOutSecond
);
  import otfs_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] relayFunc_reg;
  logic [7:0] oc1Func_reg;
  logic [7:0] oc2Func_reg;
  logic [15:0] polarity_reg;
  logic analogSel_reg;
  logic [15:0] levelHigh_reg;
  logic [15:0] levelLow_reg;
  logic [15:0] cardCtrl_reg;
  logic [15:0] fieldbusCtrl_reg;
  logic levelReached_reg;
  logic [TERM_COUNT-1:0] term_reg;
  logic [15:0] rdData_reg;
  logic rdValid_reg;
  logic [TERM_COUNT-1:0] termActive;
  logic [7:0] funcCodes [TERM_COUNT];
  logic [15:0] analogSelected;
  logic [15:0] outStatus;
  logic [15:0] rdData_next;
  logic wrTaken;

  assign funcCodes[0] = relayFunc_reg;
  assign funcCodes[1] = oc1Func_reg;
  assign funcCodes[2] = oc2Func_reg;

  // ----------------------------------------------------------------
  // Parameter writes
  // ----------------------------------------------------------------
  // A frozen block ignores the bus, so a write needs the enable as well
  assign wrTaken = clkEnable && paramReq.wrEn;

  // Function code of each terminal
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      relayFunc_reg <= FUNC_RESET;
      oc1Func_reg <= FUNC_RESET;
      oc2Func_reg <= FUNC_RESET;
    end else if (wrTaken) begin
      if (paramReq.addr == ADDR_RELAY_FUNC) begin
        relayFunc_reg <= paramReq.wrData[7:0];
      end
      if (paramReq.addr == ADDR_OC1_FUNC) begin
        oc1Func_reg <= paramReq.wrData[7:0];
      end
      if (paramReq.addr == ADDR_OC2_FUNC) begin
        oc2Func_reg <= paramReq.wrData[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      polarity_reg <= POLARITY_RESET;
    end else if (wrTaken && paramReq.addr == ADDR_POLARITY) begin
      polarity_reg <= paramReq.wrData & POLARITY_WRITE_MASK;
    end
  end

  // Comparator setup
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      analogSel_reg <= ANALOG_SEL_RESET;
      levelHigh_reg <= LEVEL_HIGH_RESET;
      levelLow_reg <= LEVEL_LOW_RESET;
    end else if (wrTaken) begin
      if (paramReq.addr == ADDR_ANALOG_SEL) begin
        analogSel_reg <= paramReq.wrData[0];
      end
      // Thresholds are not checked against each other; high below low gives a bare compare
      if (paramReq.addr == ADDR_LEVEL_HIGH) begin
        levelHigh_reg <= paramReq.wrData;
      end
      if (paramReq.addr == ADDR_LEVEL_LOW) begin
        levelLow_reg <= paramReq.wrData;
      end
    end
  end

  // Card word and fieldbus object
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cardCtrl_reg <= CARD_CTRL_RESET;
      fieldbusCtrl_reg <= FIELDBUS_CTRL_RESET;
    end else if (wrTaken) begin
      if (paramReq.addr == ADDR_CARD_CTRL) begin
        cardCtrl_reg <= paramReq.wrData;
      end
      if (paramReq.addr == ADDR_FIELDBUS_CTRL) begin
        fieldbusCtrl_reg <= paramReq.wrData;
      end
    end
  end

  // ----------------------------------------------------------------
  // Level window comparator
  // ----------------------------------------------------------------
  // pick analog channel
  assign analogSelected = analogSel_reg ? currentAnalogIn : voltageAnalogIn;

  // Hysteresis keeps the output steady while the input sits inside the window
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      levelReached_reg <= 1'b0;
    end else if (clkEnable) begin
      if (analogSelected > levelHigh_reg) begin
        levelReached_reg <= 1'b1;
      end else if (analogSelected < levelLow_reg) begin
        levelReached_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Terminals
  // ----------------------------------------------------------------
  for (genvar g = 0; g < TERM_COUNT; g++) begin : gTerm
    localparam int unsigned B = TERM_BITS[g];

    otfs_term_select otfs_term_select_inst (
      .funcCode(funcCodes[g]),
      .fieldbusBit(fieldbusCtrl_reg[B]),
      .cardBit(cardCtrl_reg[B]),
      .cond(cond),
      .levelReached(levelReached_reg),
      .active(termActive[g])
    );

    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        term_reg[g] <= 1'b0;
      end else if (clkEnable) begin
        term_reg[g] <= termActive[g] ^ polarity_reg[B];
      end
    end
  end

  // ----------------------------------------------------------------
  // Parameter reads
  // ----------------------------------------------------------------
  always_comb begin
    outStatus = 16'h0000;
    outStatus[TERM_BITS[0]] = term_reg[0];
    outStatus[TERM_BITS[1]] = term_reg[1];
    outStatus[TERM_BITS[2]] = term_reg[2];
  end

  always_comb begin
    case (paramReq.addr)
      ADDR_RELAY_FUNC: rdData_next = {8'h00, relayFunc_reg};
      ADDR_OC1_FUNC: rdData_next = {8'h00, oc1Func_reg};
      ADDR_OC2_FUNC: rdData_next = {8'h00, oc2Func_reg};
      ADDR_POLARITY: rdData_next = polarity_reg;
      ADDR_OUT_STATUS: rdData_next = outStatus;
      ADDR_ANALOG_SEL: rdData_next = {15'h0000, analogSel_reg};
      ADDR_LEVEL_HIGH: rdData_next = levelHigh_reg;
      ADDR_LEVEL_LOW: rdData_next = levelLow_reg;
      ADDR_CARD_CTRL: rdData_next = cardCtrl_reg;
      ADDR_FIELDBUS_CTRL: rdData_next = fieldbusCtrl_reg;
      default: rdData_next = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdData_reg <= 16'h0000;
      rdValid_reg <= 1'b0;
    end else if (clkEnable) begin
      rdValid_reg <= paramReq.rdEn;
      if (paramReq.rdEn) begin
        rdData_reg <= rdData_next;
      end
    end
  end

  assign paramRdData = rdData_reg;
  assign paramRdValid = rdValid_reg;
  assign relayOutput = term_reg[0];
  assign openCollectorOutFirst = term_reg[1];
  assign openCollectorOutSecond = term_reg[2];

endmodule // otfs_output_terminal

// ---- tb/otfs_output_terminal_sva.sv ----
// Assertion checker for the output terminal block
`timescale 1ns/1ps
module otfs_output_terminal_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clkEnable,
  input wire otfs_pkg::otfs_param_req_t paramReq,
  input wire logic [15:0] paramRdData,
  input wire logic paramRdValid,
  input wire logic relayOutput,
  input wire logic openCollectorOutFirst,
  input wire logic openCollectorOutSecond
);
  import otfs_pkg::*;
  logic rdTaken;
  logic [2:0] pins;
  assign rdTaken = paramReq.rdEn && clkEnable;
  assign pins = {openCollectorOutSecond, openCollectorOutFirst, relayOutput};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_rd_answer: assert property (rdTaken |=> paramRdValid)
    else $error("read not answered");
  chk_rd_single: assert property (clkEnable && !paramReq.rdEn |=> !paramRdValid)
    else $error("read valid without request");
  chk_rd_hold: assert property (!rdTaken |=> $stable(paramRdData))
    else $error("read data moved without read");
  chk_pol_reserved: assert property (rdTaken && paramReq.addr == ADDR_POLARITY
    |=> paramRdData[2:1] == 2'b00) else $error("reserved polarity bits set");
  chk_status_pins: assert property (rdTaken && paramReq.addr == ADDR_OUT_STATUS
    |=> {paramRdData[4:3], paramRdData[0]} == $past(pins)) else $error("status differs");
  chk_unmapped_zero: assert property (rdTaken && paramReq.addr == 16'h0000
    |=> paramRdData == 16'h0000) else $error("unmapped read not zero");
  chk_freeze_pins: assert property (!clkEnable |=> $stable(pins))
    else $error("terminals moved while frozen");
  chk_reset_clear: assert property ($fell(reset) |-> pins == 3'b000)
    else $error("terminals not cleared by reset");
  cov_read: cover property (rdTaken ##1 paramRdValid);
  cov_relay: cover property ($rose(relayOutput));
  cov_second: cover property ($rose(openCollectorOutSecond));
endmodule // otfs_output_terminal_sva

// ---- tb/otfs_load_model.sv ----
// Model of the external load wiring on the three terminals
`timescale 1ns/1ps
module otfs_load_model (
  input wire logic relayOutput,
  input wire logic openCollectorOutFirst,
  input wire logic openCollectorOutSecond,
  output logic [2:0] loadSeen
);
  // Closed contact reads high; wiring modelled without delay
  assign loadSeen = {openCollectorOutSecond, openCollectorOutFirst, relayOutput};
endmodule // otfs_load_model

// ---- tb/tb_otfs_output_terminal.sv ----
// Testbench for the output terminal block
`timescale 1ns/1ps
module tb_otfs_output_terminal;
  import otfs_pkg::*;
  logic clk_sys = 1'b0;
  logic reset;
  logic clkEnable;
  otfs_param_req_t paramReq;
  otfs_cond_t cond;
  logic [15:0] voltageAnalogIn;
  logic [15:0] currentAnalogIn;
  logic [15:0] paramRdData;
  logic paramRdValid;
  logic relayOutput;
  logic openCollectorOutFirst;
  logic openCollectorOutSecond;
  logic [2:0] loadSeen;
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  otfs_output_terminal otfs_output_terminal_inst (.clk_sys(clk_sys), .reset(reset),
    .clkEnable(clkEnable), .paramReq(paramReq), .cond(cond),
    .voltageAnalogIn(voltageAnalogIn), .currentAnalogIn(currentAnalogIn),
    .paramRdData(paramRdData), .paramRdValid(paramRdValid), .relayOutput(relayOutput),
    .openCollectorOutFirst(openCollectorOutFirst),
    .openCollectorOutSecond(openCollectorOutSecond));
  otfs_load_model otfs_load_model_inst (.relayOutput(relayOutput),
    .openCollectorOutFirst(openCollectorOutFirst),
    .openCollectorOutSecond(openCollectorOutSecond), .loadSeen(loadSeen));
  always #2 clk_sys = ~clk_sys;
  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard: the whole sequence needs well under this
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    paramReq = '{1'b1, 1'b0, a, d};
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    paramReq = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clk_sys);
    chk("rdValid", {15'h0000, paramRdValid}, 16'h0001);
    chk("rdData", paramRdData, exp);
  endtask
  // Requests stand until the next call or an idle wait replaces them
  task automatic pins(input logic [2:0] exp);
    paramReq = '0;
    @(negedge clk_sys);
    chk("pins", {13'h0000, loadSeen}, {13'h0000, exp});
  endtask
  task automatic setf(input otfs_func_t f);
    wr(ADDR_RELAY_FUNC, {8'h00, f});
    wr(ADDR_OC1_FUNC, {8'h00, f});
    wr(ADDR_OC2_FUNC, {8'h00, f});
  endtask
  initial begin
    reset = 1'b1;
    clkEnable = 1'b1;
    paramReq = '0;
    cond = '0;
    voltageAnalogIn = 16'h0000;
    currentAnalogIn = 16'h0000;
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    rd(ADDR_FIELDBUS_CTRL, 16'h0001);
    rd(ADDR_LEVEL_HIGH, 16'h01F4);
    rd(ADDR_LEVEL_LOW, 16'h0064);
    rd(16'h0000, 16'h0000);
    wr(ADDR_POLARITY, 16'hFFFF);
    rd(ADDR_POLARITY, 16'hFFF9);
    pins(3'b111);
    rd(ADDR_OUT_STATUS, 16'h0019);
    wr(ADDR_POLARITY, 16'h0000);
    clkEnable = 1'b0;
    wr(ADDR_POLARITY, 16'h0001);
    clkEnable = 1'b1;
    rd(ADDR_POLARITY, 16'h0000);
    setf(OTFS_FN_FIELDBUS);
    pins(3'b001);
    wr(ADDR_FIELDBUS_CTRL, 16'h0018);
    pins(3'b110);
    // Card master writes its word
    wr(ADDR_CARD_CTRL, 16'h0009);
    setf(OTFS_FN_CARD);
    pins(3'b011);
    setf(OTFS_FN_SAFE_A);
    pins(3'b000);
    cond.safeTorqueOff = 1'b1;
    pins(3'b111);
    setf(OTFS_FN_SAFE_B);
    pins(3'b000);
    cond = '0;
    pins(3'b111);
    cond.safetyLossFault = 1'b1;
    setf(OTFS_FN_SAFE_A);
    pins(3'b111);
    cond = '0;
    cond.overTorque4 = 1'b1;
    setf(OTFS_FN_TORQUE3);
    pins(3'b000);
    cond.overTorque3 = 1'b1;
    pins(3'b111);
    setf(OTFS_FN_TORQUE4);
    cond.overTorque4 = 1'b0;
    pins(3'b000);
    cond.overTorque3 = 1'b0;
    cond.overTorque4 = 1'b1;
    pins(3'b111);
    cond = '0;
    voltageAnalogIn = 16'h0258;
    setf(OTFS_FN_LEVEL);
    pins(3'b111);
    voltageAnalogIn = 16'h012C;
    @(negedge clk_sys);
    pins(3'b111);
    voltageAnalogIn = 16'h0032;
    @(negedge clk_sys);
    pins(3'b000);
    voltageAnalogIn = 16'h012C;
    @(negedge clk_sys);
    pins(3'b000);
    currentAnalogIn = 16'h02BC;
    wr(ADDR_ANALOG_SEL, 16'h0001);
    paramReq = '0;
    @(negedge clk_sys);
    pins(3'b111);
    reset = 1'b1;
    @(negedge clk_sys);
    reset = 1'b0;
    rd(ADDR_FIELDBUS_CTRL, 16'h0001);
    pins(3'b000);
    end_sim();
  end
endmodule // tb_otfs_output_terminal
bind otfs_output_terminal otfs_output_terminal_sva otfs_output_terminal_sva_inst (
  .clk_sys(clk_sys), .reset(reset), .clkEnable(clkEnable), .paramReq(paramReq),
  .paramRdData(paramRdData), .paramRdValid(paramRdValid), .relayOutput(relayOutput),
  .openCollectorOutFirst(openCollectorOutFirst),
  .openCollectorOutSecond(openCollectorOutSecond));
